// File: rtl/hie_regs.svh
// register offsets, field positions and reset values of the host interrupt event block
// assumes an apb slave decoding byte addresses, one 32-bit word per register
`ifndef HIE_REGS_SVH
`define HIE_REGS_SVH

// -----------------------------------------------------------------
// offsets
// -----------------------------------------------------------------
`define HIE_OFF_EVENT_SET    12'h080
`define HIE_OFF_EVENT_CLEAR  12'h084
`define HIE_OFF_EVENT_MASK   12'h088
`define HIE_OFF_CHAN_MASK_LO 12'h08c
`define HIE_OFF_CTRL         12'h090

// -----------------------------------------------------------------
// event bit positions
// -----------------------------------------------------------------
`define HIE_BIT_MAKER        30
`define HIE_BIT_XCVR_REG     26
`define HIE_BIT_OVERRUN      25
`define HIE_BIT_FATAL        24
`define HIE_BIT_MISMATCH     23
`define HIE_BIT_MISSING      22
`define HIE_BIT_ROLLOVER     21
`define HIE_BIT_PERIOD       20
`define HIE_BIT_XCVR_STAT    19
`define HIE_BIT_LINK_RESET   17
`define HIE_BIT_IDENT_DONE   16
`define HIE_BIT_ISO_RX       7
`define HIE_BIT_ISO_TX       6
`define HIE_BIT_ATOMIC       9
`define HIE_BIT_BUFFERED     8
`define HIE_BIT_REPLY_PKT    5
`define HIE_BIT_REQUEST_PKT  4
`define HIE_BIT_ASYNC_REPLY  3
`define HIE_BIT_ASYNC_REQ    2
`define HIE_BIT_REPLY_DONE   1
`define HIE_BIT_REQUEST_DONE 0

// bits that software may set and clear; bit 18 is reserved and stays out
`define HIE_SC_MASK          32'h47fb_033f
// hardware-only summary bits, maskable but never written as events
`define HIE_ISO_SUM_MASK     32'h0000_00c0
// bits whose hardware setting is blocked while the fatal bit stands (per-context dma events)
`define HIE_DMA_EVT_MASK     32'h0000_003f
// control register field: timing source enable
`define HIE_CTRL_TSE_BIT     0
`define HIE_RX_CHAN_LOW      5

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define HIE_RST_EVENT        32'h0000_0000
`define HIE_RST_MASK         32'h0000_0000
`define HIE_RST_CHAN         5'h00
`define HIE_RST_CTRL         1'h0

`endif

// File: rtl/hie_pkg.sv
// types shared by the host interrupt event block
// assumes hie_regs.svh supplies all numeric constants
package hie_pkg;

    typedef logic [31:0] hie_word_t;

    typedef struct packed {
        logic [31:0] event_bits;
        logic [31:0] mask_bits;
        logic [4:0]  rx_chan;
        logic        tse;
        logic        cyc_lsb;
        logic [31:0] rdata;
    } hie_state_s;

endpackage : hie_pkg

// File: rtl/hie_edge_det.sv
// per-bit asserting edge detector for interrupt sources
// assumes sources are synchronous to clk_sys
module hie_edge_det #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // source levels and edge pulses
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);

    logic [WIDTH-1:0] prev_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= '0;
        end else begin
            prev_q <= level;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            assign rise[gi] = level[gi] & ~prev_q[gi];
        end
    endgenerate

endmodule : hie_edge_det

// File: rtl/hie_event_reg.sv
// host interrupt event register with set/clear ports, mask, channel mask low, apb slave
// assumes apb master on clk_sys, event sources synchronous to clk_sys
//
// Contract
// - channel mask low bits 0..4 enable receive of channel equal to bit number
// - event bit sets on source rising edge and then stays set
// - writing 1 to set port sets bit; 0 leaves it alone
// - only a 1 written to clear port clears a bit
// - event reads return event bits anded with mask bits
// - bit 30 is a maker-defined event, settable and clearable
// - reserved bits read zero and ignore writes
// - iso summary bits 7 and 6 follow hardware, ignore software writes
// - bits 26..19, 17, 16 are settable and clearable events
// - bits 9, 8, 5..0 are settable and clearable events
// - bit 30 raised when serial configuration rom read completes
// - cycle overrun while timing source clears timing source enable
// - fatal fault bit set blocks normal dma context events
// - new period event raised on each toggle of cycle count lsb
//
// Implementation choice: the APB slave port.
`include "hie_regs.svh"

module hie_event_reg (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // event sources
    input  wire logic        rom_read_done,
    input  wire logic        transceiver_reg_byte_arrived,
    input  wire logic        cycle_overrun_event,
    input  wire logic        fatal_fault_event,
    input  wire logic        cycle_time_mismatch_event,
    input  wire logic        missing_cycle_event,
    input  wire logic        sixty_four_sec_rollover_event,
    input  wire logic        cycle_count_lsb,
    input  wire logic        transceiver_status_req,
    input  wire logic        link_reset_seen,
    input  wire logic        node_identify_done,
    input  wire logic        atomic_reply_fault,
    input  wire logic        buffered_write_fault,
    input  wire logic        reply_packet_event,
    input  wire logic        request_packet_event,
    input  wire logic        async_reply_buffer_event,
    input  wire logic        async_request_buffer_event,
    input  wire logic        reply_send_done,
    input  wire logic        request_send_done,
    // iso context pending levels
    input  wire logic [7:0]  iso_rx_ctx_pending,
    input  wire logic [7:0]  iso_tx_ctx_pending,
    // outputs to link and dma
    output logic [4:0]       rx_chan_enable,
    output logic             timing_source_enable,
    output logic             irq
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    hie_pkg::hie_state_s st_q;
    hie_pkg::hie_state_s st_d;

    hie_pkg::hie_word_t src_level;
    hie_pkg::hie_word_t src_rise;
    hie_pkg::hie_word_t hw_set;
    hie_pkg::hie_word_t sw_set;
    hie_pkg::hie_word_t sw_clr;
    hie_pkg::hie_word_t masked;
    logic               wr_en;
    logic               rd_en;
    logic               addr_ok;
    logic               period_tick;
    logic               rx_sum;
    logic               tx_sum;

    // -----------------------------------------------------------------
    // source collection
    // -----------------------------------------------------------------
    always_comb begin
        src_level                        = '0;
        src_level[`HIE_BIT_MAKER]        = rom_read_done;
        src_level[`HIE_BIT_XCVR_REG]     = transceiver_reg_byte_arrived;
        src_level[`HIE_BIT_OVERRUN]      = cycle_overrun_event;
        src_level[`HIE_BIT_FATAL]        = fatal_fault_event;
        src_level[`HIE_BIT_MISMATCH]     = cycle_time_mismatch_event;
        src_level[`HIE_BIT_MISSING]      = missing_cycle_event;
        src_level[`HIE_BIT_ROLLOVER]     = sixty_four_sec_rollover_event;
        src_level[`HIE_BIT_XCVR_STAT]    = transceiver_status_req;
        src_level[`HIE_BIT_LINK_RESET]   = link_reset_seen;
        src_level[`HIE_BIT_IDENT_DONE]   = node_identify_done;
        src_level[`HIE_BIT_ATOMIC]       = atomic_reply_fault;
        src_level[`HIE_BIT_BUFFERED]     = buffered_write_fault;
        src_level[`HIE_BIT_REPLY_PKT]    = reply_packet_event;
        src_level[`HIE_BIT_REQUEST_PKT]  = request_packet_event;
        src_level[`HIE_BIT_ASYNC_REPLY]  = async_reply_buffer_event;
        src_level[`HIE_BIT_ASYNC_REQ]    = async_request_buffer_event;
        src_level[`HIE_BIT_REPLY_DONE]   = reply_send_done;
        src_level[`HIE_BIT_REQUEST_DONE] = request_send_done;
    end

    hie_edge_det #(
        .WIDTH (32)
    ) u_edge (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .level   (src_level),
        .rise    (src_rise)
    );

    // either edge of the cycle count lsb marks a new period
    assign period_tick = cycle_count_lsb ^ st_q.cyc_lsb;

    // summaries are reloaded from live levels into the event bits every cycle, so they cannot go stale
    assign rx_sum = |iso_rx_ctx_pending;
    assign tx_sum = |iso_tx_ctx_pending;

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    assign addr_ok = (paddr == `HIE_OFF_EVENT_SET) || (paddr == `HIE_OFF_EVENT_CLEAR) ||
                     (paddr == `HIE_OFF_EVENT_MASK) || (paddr == `HIE_OFF_CHAN_MASK_LO) ||
                     (paddr == `HIE_OFF_CTRL);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    assign sw_set = (wr_en && paddr == `HIE_OFF_EVENT_SET) ?
                    (pwdata & `HIE_SC_MASK) : '0;
    assign sw_clr = (wr_en && paddr == `HIE_OFF_EVENT_CLEAR) ?
                    (pwdata & `HIE_SC_MASK) : '0;

    // -----------------------------------------------------------------
    // hardware set terms
    // -----------------------------------------------------------------
    always_comb begin
        hw_set                     = src_rise & `HIE_SC_MASK;
        hw_set[`HIE_BIT_PERIOD]    = period_tick;
        // a standing fatal fault keeps dma context events from setting
        if (st_q.event_bits[`HIE_BIT_FATAL]) begin
            hw_set = hw_set & ~`HIE_DMA_EVT_MASK;
        end
    end

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        st_d          = st_q;
        st_d.cyc_lsb  = cycle_count_lsb;
        // set wins over clear in the same cycle
        st_d.event_bits = ((st_q.event_bits & ~sw_clr) | sw_set | hw_set)
                          & `HIE_SC_MASK;
        st_d.event_bits[`HIE_BIT_ISO_RX] = rx_sum;
        st_d.event_bits[`HIE_BIT_ISO_TX] = tx_sum;

        if (wr_en && paddr == `HIE_OFF_EVENT_MASK) begin
            st_d.mask_bits = pwdata & (`HIE_SC_MASK | `HIE_ISO_SUM_MASK);
        end
        if (wr_en && paddr == `HIE_OFF_CHAN_MASK_LO) begin
            st_d.rx_chan = pwdata[`HIE_RX_CHAN_LOW-1:0];
        end
        if (wr_en && paddr == `HIE_OFF_CTRL) begin
            st_d.tse = pwdata[`HIE_CTRL_TSE_BIT];
        end
        // hardware clear takes priority over a simultaneous software write
        if (src_rise[`HIE_BIT_OVERRUN] && st_q.tse) begin
            st_d.tse = 1'b0;
        end

        if (rd_en) begin
            case (paddr)
                `HIE_OFF_EVENT_SET,
                `HIE_OFF_EVENT_CLEAR:  st_d.rdata = masked;
                `HIE_OFF_EVENT_MASK:   st_d.rdata = st_q.mask_bits;
                `HIE_OFF_CHAN_MASK_LO: st_d.rdata = {27'h0, st_q.rx_chan};
                `HIE_OFF_CTRL:         st_d.rdata = {31'h0, st_q.tse};
                default:               st_d.rdata = '0;
            endcase
        end
    end

    assign masked = st_q.event_bits & st_q.mask_bits;

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q.event_bits <= `HIE_RST_EVENT;
            st_q.mask_bits  <= `HIE_RST_MASK;
            st_q.rx_chan    <= `HIE_RST_CHAN;
            st_q.tse        <= `HIE_RST_CTRL;
            st_q.cyc_lsb    <= 1'b0;
            st_q.rdata      <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign prdata               = st_q.rdata;
    assign rx_chan_enable       = st_q.rx_chan;
    assign timing_source_enable = st_q.tse;
    assign irq                  = |masked;

endmodule : hie_event_reg

// File: sim/hie_checker.sv
// concurrent checks on the ports of the host interrupt event register
// assumes one clock domain and the bind at the foot of this file
`include "hie_regs.svh"

module hie_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // sources and outputs
    input wire logic        cycle_overrun_event,
    input wire logic [7:0]  iso_rx_ctx_pending,
    input wire logic [7:0]  iso_tx_ctx_pending,
    input wire logic [4:0]  rx_chan_enable,
    input wire logic        timing_source_enable,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic mapped, acc_rd, quiet, wr_clr;
    assign mapped = paddr inside {12'h080, 12'h084, 12'h088, 12'h08c, 12'h090};
    assign acc_rd = psel && penable && !pwrite;
    assign quiet  = iso_rx_ctx_pending == 8'h00 && iso_tx_ctx_pending == 8'h00;
    // a mask write may also drop irq, so it counts as a clear here
    assign wr_clr = psel && penable && pwrite && (paddr == 12'h084 || paddr == 12'h088);
    sequence chan_wr;
        psel && penable && pwrite && paddr == 12'h08c;
    endsequence
    sequence chan_rd;
        psel && !penable && !pwrite && paddr == 12'h08c ##1 penable;
    endsequence
    sequence ctl_wr;
        psel && penable && pwrite && paddr == 12'h090 && !$rose(cycle_overrun_event);
    endsequence
    ready_high_a: assert property (psel |-> pready) else $error("pready low");
    unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr) else $error("no slverr");
    mapped_ok_a: assert property (psel && penable && mapped |-> !pslverr) else $error("bad slverr");
    bad_read_a: assert property (acc_rd && !mapped |-> prdata == 32'h0) else $error("bad rdata");
    chan_write_a: assert property (chan_wr |=> {27'h0, rx_chan_enable} == ($past(pwdata) & 32'h1f))
        else $error("channel mask not written");
    chan_read_a: assert property (chan_rd |-> prdata == {27'h0, rx_chan_enable})
        else $error("channel mask read wrong");
    resv_zero_a: assert property (acc_rd && paddr[11:3] == 9'h010 |-> (prdata & 32'hb804_fc00) == 32'h0)
        else $error("reserved bit reads one");
    tse_write_a: assert property (ctl_wr |=> {31'h0, timing_source_enable} == ($past(pwdata) & 32'h1))
        else $error("control not written");
    overrun_clear_a: assert property ($rose(cycle_overrun_event) && timing_source_enable |=> !timing_source_enable)
        else $error("timing source not cleared");
    irq_sticky_a: assert property (irq && quiet && $past(quiet) && !wr_clr |=> irq)
        else $error("irq dropped without clear");
endmodule : hie_checker

bind hie_event_reg hie_checker hie_checker_i (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cycle_overrun_event(cycle_overrun_event),
    .iso_rx_ctx_pending(iso_rx_ctx_pending), .iso_tx_ctx_pending(iso_tx_ctx_pending),
    .rx_chan_enable(rx_chan_enable), .timing_source_enable(timing_source_enable), .irq(irq));

// File: sim/test_host_interrupt_event_register.sv
// self-checking bench for the host interrupt event register
// assumes hie_event_reg with the checker bound onto it
module test_host_interrupt_event_register;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, rst_b = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, tse, irq;
    logic [18:0] src = 19'h0;
    logic [7:0]  rxp = 8'h00, txp = 8'h00;
    logic [4:0]  chan;
    int          err_count = 0, n_tests = 0;
    int          pos[19] = '{0, 1, 2, 3, 4, 5, 8, 9, 16, 17, 19, 20, 21, 22, 23, 24, 25, 26, 30};

    always #2.5 clk_sys = ~clk_sys;

    hie_event_reg hie_event_reg_i (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rom_read_done(src[18]),
        .transceiver_reg_byte_arrived(src[17]), .cycle_overrun_event(src[16]),
        .fatal_fault_event(src[15]), .cycle_time_mismatch_event(src[14]),
        .missing_cycle_event(src[13]), .sixty_four_sec_rollover_event(src[12]),
        .cycle_count_lsb(src[11]), .transceiver_status_req(src[10]), .link_reset_seen(src[9]),
        .node_identify_done(src[8]), .atomic_reply_fault(src[7]), .buffered_write_fault(src[6]),
        .reply_packet_event(src[5]), .request_packet_event(src[4]),
        .async_reply_buffer_event(src[3]), .async_request_buffer_event(src[2]),
        .reply_send_done(src[1]), .request_send_done(src[0]), .iso_rx_ctx_pending(rxp),
        .iso_tx_ctx_pending(txp), .rx_chan_enable(chan), .timing_source_enable(tse), .irq(irq));

    task automatic end_of_test;
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask : chk

    // one idle edge first, so back-to-back calls never drive psel twice in a step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            end_of_test();
        end
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(q, e);
    endtask : rd

    task automatic t_regs;
        rd(12'h080, 32'h0);
        rd(12'h088, 32'h0);
        rd(12'h08c, 32'h0);
        rd(12'h090, 32'h0);
        apb(12'h088, 1'b1, 32'hffff_ffff);
        rd(12'h088, 32'h47fb_03ff);
        rd(12'h094, 32'h0);
    endtask : t_regs

    task automatic t_setclr;
        apb(12'h080, 1'b1, 32'hfeff_ffff);
        rd(12'h080, 32'h46fb_033f);
        chk({31'h0, irq}, 32'h1);
        apb(12'h084, 1'b1, 32'h0);
        rd(12'h084, 32'h46fb_033f);
        apb(12'h088, 1'b1, 32'h0);
        rd(12'h080, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(12'h088, 1'b1, 32'hffff_ffff);
        apb(12'h084, 1'b1, 32'hffff_ffff);
        rd(12'h080, 32'h0);
        apb(12'h080, 1'b1, 32'h0100_0000);
        // a standing fatal bit must swallow a dma context edge
        src[0] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        src[0] <= 1'b0;
        rd(12'h080, 32'h0100_0000);
        apb(12'h084, 1'b1, 32'hffff_ffff);
    endtask : t_setclr

    // cycle lsb also sets on its fall, which lands before the read
    task automatic t_edges;
        for (int i = 0; i < 19; i++) begin
            @(posedge clk_sys);
            src[i] <= 1'b1;
            repeat (2) @(posedge clk_sys);
            src[i] <= 1'b0;
            repeat (2) @(posedge clk_sys);
            rd(12'h080, 32'h1 << pos[i]);
            apb(12'h084, 1'b1, 32'hffff_ffff);
        end
    endtask : t_edges

    task automatic t_ctl;
        apb(12'h090, 1'b1, 32'h1);
        rd(12'h090, 32'h1);
        @(posedge clk_sys);
        src[16] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({31'h0, tse}, 32'h0);
        src[16] <= 1'b0;
        for (int n = 0; n < 5; n++) begin
            apb(12'h08c, 1'b1, 32'hffff_ffe0 | (32'h1 << n));
            @(posedge clk_sys);
            chk({27'h0, chan}, 32'h1 << n);
        end
        apb(12'h084, 1'b1, 32'hffff_ffff);
    endtask : t_ctl

    task automatic t_iso;
        @(posedge clk_sys);
        rxp <= 8'h10;
        repeat (3) @(posedge clk_sys);
        rd(12'h080, 32'h80);
        txp <= 8'h01;
        repeat (3) @(posedge clk_sys);
        apb(12'h084, 1'b1, 32'hffff_ffff);
        rd(12'h080, 32'hc0);
        rxp <= 8'h00;
        txp <= 8'h00;
        repeat (3) @(posedge clk_sys);
        apb(12'h080, 1'b1, 32'hc0);
        rd(12'h080, 32'h0);
    endtask : t_iso

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs();
        t_setclr();
        t_edges();
        t_ctl();
        t_iso();
        end_of_test();
    end
endmodule : test_host_interrupt_event_register
